//--- core/bpd_byte_alu.sv
// Purpose: Combinational byte arithmetic, logic, compare and extend
// Assumes: Caller applies the write enables
// Notes:   Overflow leaves the byte at the full-scale negative value
`timescale 1ns/100ps
`default_nettype none
module bpd_byte_alu
    import bpd_pkg::*;
(
    bpd_alu_if.alu p
);
    wire logic [BYTE_W-1:0] b = p.a[BYTE_W-1:0];
    wire logic [HI_W-1:0] hi = p.a[WORD_W-1:BYTE_W];
    wire logic [BYTE_W-1:0] neg_b = BYTE_W'(~b + 8'h01);
    wire logic [BYTE_W-1:0] and_b = b & p.operand;
    wire logic [BYTE_W-1:0] or_b = b | p.operand;
    wire logic [BYTE_W-1:0] abs_b = b[BYTE_W-1] ? neg_b : b;
    wire logic full_neg = (b == BYTE_FULL_NEG);

    always_comb begin
        p.a_new = p.a;
        p.a_we = 1'b0;
        p.cond = COND_ZERO;
        p.cond_we = 1'b0;
        p.ovf_set = 1'b0;
        case (p.op)
            OPC_COMPARE_MEMORY_BYTE: begin
                p.cond = bpd_cmp(b, p.mem_byte, 1'b1);
                p.cond_we = 1'b1;
            end
            OPC_COMPARE_OPERAND_BYTE: begin
                p.cond = bpd_cmp(b, p.operand, 1'b1);
                p.cond_we = 1'b1;
            end
            OPC_LOGICAL_COMPARE_OPERAND_BYTE: begin
                p.cond = bpd_cmp(b, p.operand, 1'b0);
                p.cond_we = 1'b1;
            end
            OPC_AND_OPERAND_BYTE: begin
                p.a_new = {hi, and_b};
                p.a_we = 1'b1;
                p.cond = bpd_cond8(and_b);
                p.cond_we = 1'b1;
            end
            OPC_OR_OPERAND_BYTE: begin
                p.a_new = {hi, or_b};
                p.a_we = 1'b1;
                p.cond = bpd_cond8(or_b);
                p.cond_we = 1'b1;
            end
            OPC_QUERY_BYTE_BITS: begin
                p.cond = bpd_cond8(and_b);
                p.cond_we = 1'b1;
            end
            OPC_NEGATE_BYTE: begin
                p.a_new = {hi, neg_b};
                p.a_we = 1'b1;
                p.cond = bpd_cond8(neg_b);
                p.cond_we = 1'b1;
                p.ovf_set = full_neg;
            end
            OPC_ABSOLUTE_BYTE: begin
                p.a_new = {hi, abs_b};
                p.a_we = 1'b1;
                p.cond = bpd_cond8(abs_b);
                p.cond_we = 1'b1;
                p.ovf_set = full_neg;
            end
            OPC_EXTRACT_MEMORY_BYTE: begin
                p.a_new = {hi, p.mem_byte};
                p.a_we = 1'b1;
                p.cond = bpd_cond8(p.mem_byte);
                p.cond_we = 1'b1;
            end
            OPC_EXTEND_SIGN_BYTE: begin
                p.a_new = {{HI_W{b[BYTE_W-1]}}, b};
                p.a_we = 1'b1;
                p.cond = bpd_cond24({{HI_W{b[BYTE_W-1]}}, b});
                p.cond_we = 1'b1;
            end
            OPC_EXTEND_ZERO_BYTE: begin
                p.a_new = {{HI_W{1'b0}}, b};
                p.a_we = 1'b1;
            end
            default: begin
                p.a_we = 1'b0;
            end
        endcase
    end
endmodule // bpd_byte_alu
`default_nettype wire

//--- core/bpd_byte_lane.sv
// Purpose: Byte lane select for extract and merge for replace
// Assumes: Select field taken from index bits 23:22
// Notes:   Field 00 extracts the right byte but never merges
`timescale 1ns/100ps
`default_nettype none
module bpd_byte_lane
    import bpd_pkg::*;
(
    input wire logic [SEL_W-1:0] i_sel,
    input wire logic [WORD_W-1:0] i_word,
    input wire logic [BYTE_W-1:0] i_byte,
    output logic [BYTE_W-1:0] o_byte,
    output logic [WORD_W-1:0] o_merged,
    output logic o_merge_en
);
    assign o_byte = (i_sel == SEL_LEFT) ? i_word[WORD_W-1 -: BYTE_W] :
                    (i_sel == SEL_MID) ? i_word[2*BYTE_W-1 -: BYTE_W] :
                    i_word[BYTE_W-1:0];
    assign o_merged = (i_sel == SEL_LEFT) ? {i_byte, i_word[2*BYTE_W-1:0]} :
                      (i_sel == SEL_MID) ? {i_word[WORD_W-1 -: BYTE_W], i_byte, i_word[BYTE_W-1:0]} :
                      {i_word[WORD_W-1:BYTE_W], i_byte};
    assign o_merge_en = (i_sel != SEL_NONE);
endmodule // bpd_byte_lane
`default_nettype wire

//--- core/bpd_core.sv
// Purpose: Byte processing datapath of a 24-bit execution unit
// Assumes: Memory and sequencer run on I_CLK; no synchronisers needed
// Notes:   One instruction at a time; start and load ignored while busy
//
// How it works
// - byte_branch_j adds one to J bits 23:22; nonzero result branches to address.
// - On wrap to zero, field becomes 01 and J bits 21-0 increment.
// - Word part wrapping to zero falls through; otherwise branch taken.
// - compare_memory_byte signed-compares byte register with memory bits 7-0.
// - compare_operand_byte signed-compares byte register with immediate, condition only.
// - and_operand_byte ANDs immediate into byte, keeps upper bits, sets condition.
// - extract_memory_byte reads effective address plus J, loads selected byte.
// - Extract select 01 left, 10 middle, 11 and 00 right byte.
// - Requested indexing adds index register to address before J is added.
// - extend_sign_byte copies bit 7 upward, condition from whole accumulator.
// - extend_zero_byte clears upper bits, condition untouched.
// - logical_compare_operand_byte compares unsigned, condition only.
// - negate_byte two's complements byte, overflow at full-scale negative.
// - or_operand_byte ORs immediate into byte, keeps upper bits, sets condition.
// - absolute_byte takes absolute value, overflow at full-scale negative.
// - replace_memory_byte writes byte into selected lane at address plus I.
// - Replace select 01 left, 10 middle, 11 right, 00 no write.
// - Requested indexing ORs index register with I before the add.
// - query_byte_bits ANDs immediate with byte, sets condition, stores nothing.
`timescale 1ns/100ps
`default_nettype none
module bpd_core
    import bpd_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_START,
    input wire logic [3:0] I_OPCODE,
    input wire logic [BYTE_W-1:0] I_OPERAND,
    input wire logic [PC_W-1:0] I_EA,
    input wire logic I_IDX_EN,
    input wire logic [WORD_W-1:0] I_IDX,
    input wire logic I_LOAD_EN,
    input wire logic [1:0] I_LOAD_SEL,
    input wire logic [WORD_W-1:0] I_LOAD_DATA,
    input wire logic I_OVF_CLR,
    input wire logic I_MEM_ACK,
    input wire logic [WORD_W-1:0] I_MEM_RDATA,
    output logic O_BUSY,
    output logic O_DONE,
    output logic O_MEM_REQ,
    output logic O_MEM_WE,
    output logic [WADDR_W-1:0] O_MEM_ADDR,
    output logic [WORD_W-1:0] O_MEM_WDATA,
    output logic [WORD_W-1:0] O_A,
    output logic [WORD_W-1:0] O_I,
    output logic [WORD_W-1:0] O_J,
    output logic [PC_W-1:0] O_PC,
    output logic [2:0] O_COND,
    output logic O_OVF
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } bpd_state_t;

    bpd_state_t state_q;
    bpd_state_t state_d;

    logic [WORD_W-1:0] a_q;
    logic [WORD_W-1:0] a_d;
    logic [WORD_W-1:0] i_q;
    logic [WORD_W-1:0] i_d;
    logic [WORD_W-1:0] j_q;
    logic [WORD_W-1:0] j_d;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [2:0] cond_q;
    logic [2:0] cond_d;
    logic ovf_q;
    logic ovf_d;
    logic done_q;
    logic done_d;
    logic req_q;
    logic req_d;
    logic we_q;
    logic we_d;
    logic [WADDR_W-1:0] addr_q;
    logic [WADDR_W-1:0] addr_d;
    logic [WORD_W-1:0] wdata_q;
    logic [WORD_W-1:0] wdata_d;
    bpd_op_t op_q;
    bpd_op_t op_d;
    logic [SEL_W-1:0] sel_q;
    logic [SEL_W-1:0] sel_d;

    bpd_alu_if alu_bus();

    // Request decode
    wire logic idle = (state_q == ST_IDLE);
    wire bpd_op_t op_in = bpd_op_t'(I_OPCODE);
    wire logic go = idle & I_START;
    wire logic load = idle & I_LOAD_EN & ~I_START;
    wire logic op_stp = (op_in == OPC_BYTE_BRANCH_J);
    wire logic op_ext = (op_in == OPC_EXTRACT_MEMORY_BYTE);
    wire logic op_cmp = (op_in == OPC_COMPARE_MEMORY_BYTE);
    wire logic op_rep = (op_in == OPC_REPLACE_MEMORY_BYTE);
    wire logic op_read = op_ext | op_cmp;

    // Address formation
    wire logic [WORD_W-1:0] ea_word = {{(WORD_W-PC_W){1'b0}}, I_EA};
    wire logic [WORD_W-1:0] ea_idx = I_IDX_EN ? WORD_W'(ea_word + I_IDX) : ea_word;
    wire logic [WADDR_W-1:0] ext_addr = WADDR_W'(ea_idx[WADDR_W-1:0] + j_q[WADDR_W-1:0]);
    wire logic [WORD_W-1:0] rep_base = I_IDX_EN ? (i_q | I_IDX) : i_q;
    wire logic [WADDR_W-1:0] rep_addr = WADDR_W'(rep_base[WADDR_W-1:0] + ea_word[WADDR_W-1:0]);
    wire logic [WADDR_W-1:0] cmp_addr = ea_idx[WADDR_W-1:0];
    wire logic [SEL_W-1:0] j_sel = j_q[WORD_W-1:SEL_LSB];
    wire logic [SEL_W-1:0] i_sel = i_q[WORD_W-1:SEL_LSB];
    wire logic rep_skip = (i_sel == SEL_NONE);

    // Byte pointer step on J
    wire logic [SEL_W-1:0] stp_field = SEL_W'(j_sel + SEL_STEP);
    wire logic stp_field_nz = (stp_field != SEL_NONE);
    wire logic [WADDR_W-1:0] stp_word = WADDR_W'(j_q[WADDR_W-1:0] + WADDR_STEP);
    wire logic stp_word_nz = (stp_word != '0);
    wire logic [WORD_W-1:0] stp_j = stp_field_nz ? {stp_field, j_q[WADDR_W-1:0]} :
                                    {SEL_WRAP_RELOAD, stp_word};
    wire logic stp_take = stp_field_nz | stp_word_nz;
    wire logic [PC_W-1:0] pc_next = PC_W'(pc_q + PC_STEP);

    // Byte lane for extract (J field) and replace (I field)
    logic [BYTE_W-1:0] lane_byte;
    logic [WORD_W-1:0] lane_merged;
    logic lane_merge_en;

    bpd_byte_lane u_lane (
        .i_sel(sel_q),
        .i_word(I_MEM_RDATA),
        .i_byte(a_q[BYTE_W-1:0]),
        .o_byte(lane_byte),
        .o_merged(lane_merged),
        .o_merge_en(lane_merge_en)
    );

    // ALU sees the new request in idle and the held one while reading
    assign alu_bus.op = idle ? op_in : op_q;
    assign alu_bus.a = a_q;
    assign alu_bus.operand = I_OPERAND;
    assign alu_bus.mem_byte = (op_q == OPC_EXTRACT_MEMORY_BYTE) ? lane_byte : I_MEM_RDATA[BYTE_W-1:0];

    bpd_byte_alu u_alu (
        .p(alu_bus.alu)
    );

    wire logic mem_back = (state_q == ST_READ) & I_MEM_ACK;
    wire logic alu_fire = (go & ~op_read & ~op_rep & ~op_stp) | (mem_back & (op_q != OPC_REPLACE_MEMORY_BYTE));

    always_comb begin
        state_d = state_q;
        a_d = a_q;
        i_d = i_q;
        j_d = j_q;
        pc_d = pc_q;
        cond_d = cond_q;
        ovf_d = ovf_q & ~I_OVF_CLR;
        done_d = 1'b0;
        req_d = req_q;
        we_d = we_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        op_d = op_q;
        sel_d = sel_q;
        if (alu_fire) begin
            if (alu_bus.a_we) begin
                a_d = alu_bus.a_new;
            end
            if (alu_bus.cond_we) begin
                cond_d = alu_bus.cond;
            end
            if (alu_bus.ovf_set) begin
                ovf_d = 1'b1;
            end
        end
        case (state_q)
            ST_IDLE: begin
                if (load) begin
                    case (I_LOAD_SEL)
                        LD_A: a_d = I_LOAD_DATA;
                        LD_I: i_d = I_LOAD_DATA;
                        LD_J: j_d = I_LOAD_DATA;
                        default: pc_d = I_LOAD_DATA[PC_W-1:0];
                    endcase
                end
                if (go) begin
                    op_d = op_in;
                    if (op_stp) begin
                        j_d = stp_j;
                        pc_d = stp_take ? I_EA : pc_next;
                        done_d = 1'b1;
                    end else if (op_read) begin
                        sel_d = j_sel;
                        addr_d = op_ext ? ext_addr : cmp_addr;
                        req_d = 1'b1;
                        we_d = 1'b0;
                        pc_d = pc_next;
                        state_d = ST_READ;
                    end else if (op_rep) begin
                        pc_d = pc_next;
                        if (rep_skip) begin
                            done_d = 1'b1;
                        end else begin
                            sel_d = i_sel;
                            addr_d = rep_addr;
                            req_d = 1'b1;
                            we_d = 1'b0;
                            state_d = ST_READ;
                        end
                    end else begin
                        pc_d = pc_next;
                        done_d = 1'b1;
                    end
                end
            end
            ST_READ: begin
                if (I_MEM_ACK) begin
                    if (op_q == OPC_REPLACE_MEMORY_BYTE) begin
                        // Read-modify-write keeps the two untouched lanes intact
                        wdata_d = lane_merged;
                        we_d = lane_merge_en;
                        req_d = lane_merge_en;
                        done_d = ~lane_merge_en;
                        state_d = lane_merge_en ? ST_WRITE : ST_IDLE;
                    end else begin
                        req_d = 1'b0;
                        done_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_WRITE: begin
                if (I_MEM_ACK) begin
                    req_d = 1'b0;
                    we_d = 1'b0;
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                req_d = 1'b0;
                we_d = 1'b0;
                state_d = ST_IDLE;
            end
        endcase
    end

    // Architectural registers
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            a_q <= WORD_RST;
            i_q <= WORD_RST;
            j_q <= WORD_RST;
            pc_q <= PC_RST;
            cond_q <= COND_RST;
            ovf_q <= 1'b0;
        end else begin
            a_q <= a_d;
            i_q <= i_d;
            j_q <= j_d;
            pc_q <= pc_d;
            cond_q <= cond_d;
            ovf_q <= ovf_d;
        end
    end

    // Sequencing and memory port
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_q <= ST_IDLE;
            done_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= WORD_RST;
            op_q <= OPC_BYTE_BRANCH_J;
            sel_q <= SEL_NONE;
        end else begin
            state_q <= state_d;
            done_q <= done_d;
            req_q <= req_d;
            we_q <= we_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            op_q <= op_d;
            sel_q <= sel_d;
        end
    end

    assign O_BUSY = ~state_q[0];
    assign O_DONE = done_q;
    assign O_MEM_REQ = req_q;
    assign O_MEM_WE = we_q;
    assign O_MEM_ADDR = addr_q;
    assign O_MEM_WDATA = wdata_q;
    assign O_A = a_q;
    assign O_I = i_q;
    assign O_J = j_q;
    assign O_PC = pc_q;
    assign O_COND = cond_q;
    assign O_OVF = ovf_q;
endmodule // bpd_core
`default_nettype wire

//--- include/bpd_alu_if.sv
// Purpose: Carrier between the sequencer core and the byte ALU
// Assumes: Purely combinational ALU on the far side
// Notes:   None
`timescale 1ns/100ps
`default_nettype none
interface bpd_alu_if;
    import bpd_pkg::*;
    bpd_op_t op;
    logic [WORD_W-1:0] a;
    logic [BYTE_W-1:0] operand;
    logic [BYTE_W-1:0] mem_byte;
    logic [WORD_W-1:0] a_new;
    logic a_we;
    logic [2:0] cond;
    logic cond_we;
    logic ovf_set;
    modport core(output op, a, operand, mem_byte, input a_new, a_we, cond, cond_we, ovf_set);
    modport alu(input op, a, operand, mem_byte, output a_new, a_we, cond, cond_we, ovf_set);
endinterface
`default_nettype wire

//--- include/bpd_pkg.sv
// Purpose: Shared constants, types and helpers of the byte datapath
// Assumes: 24-bit words, byte register is accumulator bits 7-0
// Notes:   Condition codes are one-hot: positive, negative, zero
package bpd_pkg;
    localparam int WORD_W = 24;
    localparam int BYTE_W = 8;
    localparam int PC_W = 15;
    localparam int WADDR_W = 22;
    localparam int SEL_W = 2;
    localparam int SEL_LSB = 22;
    localparam int HI_W = WORD_W - BYTE_W;
    localparam logic [SEL_W-1:0] SEL_NONE = 2'h0;
    localparam logic [SEL_W-1:0] SEL_LEFT = 2'h1;
    localparam logic [SEL_W-1:0] SEL_MID = 2'h2;
    localparam logic [SEL_W-1:0] SEL_RIGHT = 2'h3;
    localparam logic [SEL_W-1:0] SEL_WRAP_RELOAD = 2'h1;
    localparam logic [BYTE_W-1:0] BYTE_FULL_NEG = 8'h80;
    localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
    localparam logic [WADDR_W-1:0] WADDR_STEP = 22'h000001;
    localparam logic [SEL_W-1:0] SEL_STEP = 2'h1;
    localparam logic [2:0] COND_POS = 3'h1;
    localparam logic [2:0] COND_NEG = 3'h2;
    localparam logic [2:0] COND_ZERO = 3'h4;
    localparam logic [2:0] COND_RST = 3'h4;
    localparam logic [1:0] LD_A = 2'h0;
    localparam logic [1:0] LD_I = 2'h1;
    localparam logic [1:0] LD_J = 2'h2;
    localparam logic [1:0] LD_PC = 2'h3;

    typedef enum logic [3:0] {
        OPC_BYTE_BRANCH_J = 4'h0,
        OPC_COMPARE_MEMORY_BYTE = 4'h1,
        OPC_COMPARE_OPERAND_BYTE = 4'h2,
        OPC_AND_OPERAND_BYTE = 4'h3,
        OPC_EXTRACT_MEMORY_BYTE = 4'h4,
        OPC_EXTEND_SIGN_BYTE = 4'h5,
        OPC_EXTEND_ZERO_BYTE = 4'h6,
        OPC_LOGICAL_COMPARE_OPERAND_BYTE = 4'h7,
        OPC_NEGATE_BYTE = 4'h8,
        OPC_OR_OPERAND_BYTE = 4'h9,
        OPC_ABSOLUTE_BYTE = 4'ha,
        OPC_REPLACE_MEMORY_BYTE = 4'hb,
        OPC_QUERY_BYTE_BITS = 4'hc
    } bpd_op_t;

    function automatic logic [2:0] bpd_cond8(input logic [BYTE_W-1:0] v);
        bpd_cond8 = (v == '0) ? COND_ZERO : (v[BYTE_W-1] ? COND_NEG : COND_POS);
    endfunction

    function automatic logic [2:0] bpd_cond24(input logic [WORD_W-1:0] v);
        bpd_cond24 = (v == '0) ? COND_ZERO : (v[WORD_W-1] ? COND_NEG : COND_POS);
    endfunction

    // Byte register measured against the other operand
    function automatic logic [2:0] bpd_cmp(input logic [BYTE_W-1:0] b, input logic [BYTE_W-1:0] o,
                                           input logic signed_cmp);
        logic lt;
        lt = signed_cmp ? ($signed(b) < $signed(o)) : (b < o);
        bpd_cmp = (b == o) ? COND_ZERO : (lt ? COND_NEG : COND_POS);
    endfunction
endpackage

//--- sim/bpd_core_chk.sv
// Purpose: Port assertions for the byte datapath
// Assumes: Bound onto bpd_core, one clock domain
// Notes: None
`timescale 1ns/100ps
`default_nettype none
module bpd_core_chk
    import bpd_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_START,
    input wire logic [3:0] I_OPCODE,
    input wire logic [BYTE_W-1:0] I_OPERAND,
    input wire logic [PC_W-1:0] I_EA,
    input wire logic I_IDX_EN,
    input wire logic O_BUSY,
    input wire logic O_DONE,
    input wire logic O_MEM_REQ,
    input wire logic [WORD_W-1:0] O_A,
    input wire logic [WORD_W-1:0] O_I,
    input wire logic [WORD_W-1:0] O_J,
    input wire logic [PC_W-1:0] O_PC,
    input wire logic [2:0] O_COND,
    input wire logic O_OVF
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    wire logic go = I_START && !O_BUSY;
    wire logic stp = go && I_OPCODE == OPC_BYTE_BRANCH_J;
    wire logic wrap = stp && O_J[23:22] == 2'h3;

    AST_STP_INC: assert property (stp && !wrap |=> O_PC == $past(I_EA) &&
        O_J == {$past(O_J[23:22]) + SEL_STEP, $past(O_J[21:0])}) else $error("step");
    AST_STP_WRAP: assert property (wrap && O_J[21:0] != '1 |=> O_PC == $past(I_EA) &&
        O_J == {SEL_WRAP_RELOAD, $past(O_J[21:0]) + WADDR_STEP}) else $error("wrap");
    AST_STP_FALL: assert property (wrap && O_J[21:0] == '1 |=> O_J == 24'h400000 &&
        O_PC == $past(O_PC) + PC_STEP) else $error("fall");
    AST_CMP_IMM: assert property (go && I_OPCODE == OPC_COMPARE_OPERAND_BYTE |=> $stable(O_A) &&
        O_COND == (($past(I_OPERAND) == $past(O_A[7:0])) ? COND_ZERO :
        ($signed($past(O_A[7:0])) > $signed($past(I_OPERAND))) ? COND_POS : COND_NEG))
        else $error("compare");
    AST_AND: assert property (go && I_OPCODE == OPC_AND_OPERAND_BYTE |=>
        O_A == {$past(O_A[23:8]), $past(O_A[7:0] & I_OPERAND)}) else $error("and");
    AST_SEXT: assert property (go && I_OPCODE == OPC_EXTEND_SIGN_BYTE |=>
        O_A == {{16{$past(O_A[7])}}, $past(O_A[7:0])}) else $error("sext");
    AST_ZEXT: assert property (go && I_OPCODE == OPC_EXTEND_ZERO_BYTE |=>
        O_A == {16'h0000, $past(O_A[7:0])} && $stable(O_COND)) else $error("zext");
    AST_NEG: assert property (go && I_OPCODE == OPC_NEGATE_BYTE |=>
        O_A == {$past(O_A[23:8]), 8'h00 - $past(O_A[7:0])}) else $error("negate");
    AST_OVF: assert property (go && (I_OPCODE == OPC_NEGATE_BYTE || I_OPCODE == OPC_ABSOLUTE_BYTE) &&
        O_A[7:0] == BYTE_FULL_NEG |=> O_OVF && O_A[7:0] == BYTE_FULL_NEG) else $error("overflow");
    AST_QUERY: assert property (go && I_OPCODE == OPC_QUERY_BYTE_BITS |=> $stable(O_A))
        else $error("query");
    AST_REP_SKIP: assert property (go && I_OPCODE == OPC_REPLACE_MEMORY_BYTE && !I_IDX_EN &&
        O_I[23:22] == SEL_NONE |=> O_DONE && !O_MEM_REQ) else $error("skip");

    cover property (wrap);
    cover property (go && I_OPCODE == OPC_REPLACE_MEMORY_BYTE ##[2:20] O_DONE);
    cover property ($rose(O_OVF));
endmodule // bpd_core_chk
`default_nettype wire

//--- sim/bpd_core_test.sv
// Purpose: Self-checking bench of the byte datapath
// Assumes: Memory model answers after a set latency
// Notes: Inputs move 1 ns after each edge
`timescale 1ns/100ps
`default_nettype none
module bpd_core_test
    import bpd_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0, ld = 1'b0, idx_en = 1'b0, ovf_clr = 1'b0;
    logic [3:0] opc = 4'h0, lat = 4'h0;
    logic [7:0] opd = 8'h00;
    logic [14:0] ea = 15'h0000;
    logic [1:0] ld_sel = 2'h0;
    logic [23:0] idx = 24'h0, ld_d = 24'h0, rdata, mwdata, a, i, j;
    logic ack, busy, done, mreq, mwe, ovf;
    logic [21:0] maddr;
    logic [14:0] pc;
    logic [2:0] cond;
    int bad_count = 0;
    int cmp_count = 0;
    always #4 clk = ~clk;
    bpd_core i_bpd_core(.I_CLK(clk), .I_RST(rst), .I_START(start), .I_OPCODE(opc), .I_OPERAND(opd), .I_EA(ea),
        .I_IDX_EN(idx_en), .I_IDX(idx), .I_LOAD_EN(ld), .I_LOAD_SEL(ld_sel), .I_LOAD_DATA(ld_d),
        .I_OVF_CLR(ovf_clr), .I_MEM_ACK(ack), .I_MEM_RDATA(rdata), .O_BUSY(busy), .O_DONE(done),
        .O_MEM_REQ(mreq), .O_MEM_WE(mwe), .O_MEM_ADDR(maddr), .O_MEM_WDATA(mwdata), .O_A(a), .O_I(i),
        .O_J(j), .O_PC(pc), .O_COND(cond), .O_OVF(ovf));
    bpd_mem_model i_bpd_mem_model(.i_clk(clk), .i_rst(rst), .i_req(mreq), .i_we(mwe), .i_addr(maddr),
        .i_wdata(mwdata), .i_lat(lat), .o_ack(ack), .o_rdata(rdata));

    task report_and_stop;
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task tick;
        @(posedge clk);
        #1;
    endtask
    task chk(input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %0t %h %h", $time, e, g);
        end
    endtask
    task load(input logic [1:0] s, input logic [23:0] d);
        ld <= 1'b1;
        ld_sel <= s;
        ld_d <= d;
        tick;
        ld <= 1'b0;
    endtask
    task run(input logic [3:0] op, input logic [7:0] o, input logic [14:0] e);
        int n;
        start <= 1'b1;
        opc <= op;
        opd <= o;
        ea <= e;
        tick;
        start <= 1'b0;
        for (n = 0; done !== 1'b1 && n < 60; n++)
            tick;
        if (n == 60) begin
            bad_count++;
            report_and_stop;
        end
    endtask
    task rc(input logic [3:0] op, input logic [7:0] o, input logic [23:0] xa, input logic [2:0] xc);
        run(op, o, 15'h0);
        chk(xa, a);
        chk(24'(xc), cond);
    endtask

    task t_step;
        load(LD_J, 24'hc00005);
        run(OPC_BYTE_BRANCH_J, 8'h0, 15'h0123);
        chk(24'h400006, j);
        chk(24'h123, 24'(pc));
        load(LD_J, 24'h400000);
        run(OPC_BYTE_BRANCH_J, 8'h0, 15'h0456);
        chk(24'h800000, j);
        chk(24'h456, 24'(pc));
        load(LD_PC, 24'h100);
        load(LD_J, 24'hffffff);
        run(OPC_BYTE_BRANCH_J, 8'h0, 15'h0777);
        chk(24'h400000, j);
        chk(24'h101, 24'(pc));
    endtask
    task t_alu;
        load(LD_A, 24'h5);
        rc(OPC_COMPARE_OPERAND_BYTE, 8'h05, 24'h5, COND_ZERO);
        rc(OPC_COMPARE_OPERAND_BYTE, 8'hfb, 24'h5, COND_POS);
        rc(OPC_COMPARE_OPERAND_BYTE, 8'h7f, 24'h5, COND_NEG);
        rc(OPC_LOGICAL_COMPARE_OPERAND_BYTE, 8'hfb, 24'h5, COND_NEG);
        rc(OPC_LOGICAL_COMPARE_OPERAND_BYTE, 8'h01, 24'h5, COND_POS);
        load(LD_A, 24'h123456);
        rc(OPC_AND_OPERAND_BYTE, 8'h0f, 24'h123406, COND_POS);
        rc(OPC_OR_OPERAND_BYTE, 8'h80, 24'h123486, COND_NEG);
        rc(OPC_QUERY_BYTE_BITS, 8'h79, 24'h123486, COND_ZERO);
        rc(OPC_QUERY_BYTE_BITS, 8'h84, 24'h123486, COND_NEG);
        rc(OPC_EXTEND_SIGN_BYTE, 8'h0, 24'hffff86, COND_NEG);
        load(LD_A, 24'h45);
        rc(OPC_EXTEND_SIGN_BYTE, 8'h0, 24'h45, COND_POS);
        load(LD_A, 24'habcd00);
        rc(OPC_EXTEND_ZERO_BYTE, 8'h0, 24'h0, COND_POS);
    endtask
    task t_ovf;
        load(LD_A, 24'h111103);
        rc(OPC_NEGATE_BYTE, 8'h0, 24'h1111fd, COND_NEG);
        chk(24'h0, 24'(ovf));
        load(LD_A, 24'h80);
        rc(OPC_NEGATE_BYTE, 8'h0, 24'h80, COND_NEG);
        chk(24'h1, 24'(ovf));
        ovf_clr <= 1'b1;
        tick;
        ovf_clr <= 1'b0;
        load(LD_A, 24'h2222f0);
        rc(OPC_ABSOLUTE_BYTE, 8'h0, 24'h222210, COND_POS);
        chk(24'h0, 24'(ovf));
        load(LD_A, 24'h55aa80);
        rc(OPC_ABSOLUTE_BYTE, 8'h0, 24'h55aa80, COND_NEG);
        chk(24'h1, 24'(ovf));
    endtask
    task t_mem;
        logic [23:0] w;
        i_bpd_mem_model.mem[5] = 24'habcdf0;
        i_bpd_mem_model.mem[7] = 24'h21b243;
        lat <= 4'h3;
        load(LD_A, 24'h10);
        run(OPC_COMPARE_MEMORY_BYTE, 8'h0, 15'h5);
        chk(24'(COND_POS), cond);
        idx_en <= 1'b1;
        idx <= 24'h1;
        for (int s = 0; s < 4; s++) begin
            load(LD_A, 24'h5a5a00);
            load(LD_J, {s[1:0], 22'h2});
            run(OPC_EXTRACT_MEMORY_BYTE, 8'h0, 15'h4);
            chk({16'h5a5a, s == 1 ? 8'h21 : s == 2 ? 8'hb2 : 8'h43}, a);
        end
        lat <= 4'h0;
        load(LD_A, 24'hee);
        for (int s = 0; s < 4; s++) begin
            w = (s == 1) ? 24'hee3456 : (s == 2) ? 24'h12ee56 : (s == 3) ? 24'h1234ee : 24'h123456;
            i_bpd_mem_model.mem[11] = 24'h123456;
            idx_en <= (s != 0);
            load(LD_I, {s[1:0], 22'h8});
            run(OPC_REPLACE_MEMORY_BYTE, 8'h0, 15'h2);
            chk(w, i_bpd_mem_model.mem[11]);
        end
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick;
        t_step;
        t_alu;
        t_ovf;
        t_mem;
        report_and_stop;
    end
endmodule // bpd_core_test
bind bpd_core bpd_core_chk i_bpd_core_chk(.I_CLK, .I_RST, .I_START, .I_OPCODE, .I_OPERAND, .I_EA, .I_IDX_EN,
    .O_BUSY, .O_DONE, .O_MEM_REQ, .O_A, .O_I, .O_J, .O_PC, .O_COND, .O_OVF);
`default_nettype wire

//--- sim/bpd_mem_model.sv
// Purpose: Word memory answering the datapath's requests
// Assumes: 64 words, upper address bits ignored
// Notes: Latency set by i_lat, zero is the fastest answer
`timescale 1ns/100ps
`default_nettype none
module bpd_mem_model
    import bpd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [WADDR_W-1:0] i_addr,
    input wire logic [WORD_W-1:0] i_wdata,
    input wire logic [3:0] i_lat,
    output logic o_ack,
    output logic [WORD_W-1:0] o_rdata
);
    logic [WORD_W-1:0] mem [0:63];
    logic [3:0] cnt_q;
    // Inverted data outside the answer catches a design sampling at the wrong edge
    assign o_rdata = o_ack ? mem[i_addr[5:0]] : ~mem[i_addr[5:0]];
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 4'h0;
            o_ack <= 1'b0;
        end else begin
            o_ack <= 1'b0;
            if (i_req && !o_ack) begin
                if (cnt_q >= i_lat) begin
                    o_ack <= 1'b1;
                    cnt_q <= 4'h0;
                    if (i_we) mem[i_addr[5:0]] <= i_wdata;
                end else cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule // bpd_mem_model
`default_nettype wire
